// *** design/tks_params.svh ***
// constants for the timekeeping memory port: offsets, bits, reset values, timing
`ifndef TKS_PARAMS_SVH
`define TKS_PARAMS_SVH

`define TKS_ADDR_W 13
`define TKS_CTRL_ADDR 13'h1FF8
`define TKS_IMG_BASE 13'h1FF9
`define TKS_IMG_LAST 13'h1FFF
`define TKS_READ_BIT 6
`define TKS_WRITE_BIT 7
`define TKS_CTRL_RESET 8'h00
`define TKS_UNDEF_BYTE 8'hFF

`define TKS_CLK_NS 5
`define TKS_ACCESS_NS 70
`define TKS_ACCESS_CYC ((`TKS_ACCESS_NS + `TKS_CLK_NS - 1) / `TKS_CLK_NS)
`define TKS_ONE_SEC_NS 1000000000
`define TKS_RECOVERY_NS 1000000
`define TKS_CNT_W 28

`define TKS_MASK_SEC 8'h7F
`define TKS_MASK_MIN 8'h7F
`define TKS_MASK_HOUR 8'h3F
`define TKS_MASK_DAY 8'h07
`define TKS_MASK_DATE 8'h3F
`define TKS_MASK_MONTH 8'h1F
`define TKS_MASK_YEAR 8'hFF
`define TKS_RST_SEC 8'h00
`define TKS_RST_DAY 8'h01

`endif

// *** design/tks_pkg.sv ***
// types for the timekeeping memory port
`default_nettype none
package tks_pkg;
	typedef struct packed {
		logic chipSelN;
		logic outEnN;
		logic writeEnN;
		logic [12:0] byteAddr;
		logic [7:0] dataIn;
	} tks_bus_s;

	typedef enum logic [1:0] {
		PWR_ON,
		PWR_FAIL,
		PWR_RECOVER
	} tks_pwr_e;
endpackage
`default_nettype wire

// *** design/tks_timekeeping_sram_port.sv ***
// battery-backed byte memory with control byte and mirrored clock image at the top eight bytes
`include "tks_params.svh"
`default_nettype none
module tks_timekeeping_sram_port
	import tks_pkg::*;
#(
	parameter int ONE_SEC_CYCLES = `TKS_ONE_SEC_NS / `TKS_CLK_NS,
	parameter int RECOVERY_CYCLES = `TKS_RECOVERY_NS / `TKS_CLK_NS
) (
	input wire logic mclk,
	input wire logic reset,
	input wire tks_bus_s busIn,
	input wire logic belowPowerFailThreshold,
	input wire logic belowBatterySwitchLevel,
	output logic [7:0] dataOut,
	output logic dataOe
);
	localparam int ACCESS_CYC = `TKS_ACCESS_CYC;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	function automatic logic isImage(input logic [12:0] a);
		return a >= `TKS_IMG_BASE;
	endfunction

	function automatic logic [7:0] fieldMask(input int idx);
		case (idx)
			1: return `TKS_MASK_SEC;
			2: return `TKS_MASK_MIN;
			3: return `TKS_MASK_HOUR;
			4: return `TKS_MASK_DAY;
			5: return `TKS_MASK_DATE;
			6: return `TKS_MASK_MONTH;
			default: return `TKS_MASK_YEAR;
		endcase
	endfunction

	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		if (v[3:0] >= 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end
		return {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] lastDate(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	tks_bus_s busMeta;
	tks_bus_s bus;
	logic [1:0] pwrMeta;
	logic failSync;
	logic battSync;

	always_ff @(posedge mclk) begin
		busMeta <= busIn;
		bus <= busMeta;
		pwrMeta <= {belowPowerFailThreshold, belowBatterySwitchLevel};
		{failSync, battSync} <= pwrMeta;
	end

	// ----------------------------------------------------------------
	// power-fail deselect and recovery
	// ----------------------------------------------------------------
	tks_pwr_e pwrState;
	tks_pwr_e next_pwrState;
	logic [`TKS_CNT_W-1:0] recCnt;
	logic deselReq;
	logic busOk;
	logic powerUp;

	// battery level implies power fail as well; either one deselects
	assign deselReq = failSync | battSync;
	assign busOk = (pwrState == PWR_ON);
	assign powerUp = (pwrState == PWR_RECOVER) && (recCnt == '0) && !deselReq;

	always_comb begin
		next_pwrState = pwrState;
		case (pwrState)
			PWR_ON: if (deselReq) next_pwrState = PWR_FAIL;
			PWR_FAIL: if (!deselReq) next_pwrState = PWR_RECOVER;
			PWR_RECOVER: begin
				if (deselReq) begin
					next_pwrState = PWR_FAIL;
				end else if (recCnt == '0) begin
					next_pwrState = PWR_ON;
				end
			end
			default: next_pwrState = PWR_FAIL;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pwrState <= PWR_ON;
		end else begin
			pwrState <= next_pwrState;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || pwrState != PWR_RECOVER) begin
			recCnt <= `TKS_CNT_W'(RECOVERY_CYCLES - 1);
		end else if (recCnt != '0) begin
			recCnt <= recCnt - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic selected;
	logic readMode;
	logic wrActive;
	logic wrPrev;
	logic commitEn;
	logic [12:0] wrAddr;
	logic [7:0] wrData;

	assign selected = !bus.chipSelN && busOk;
	assign readMode = selected && bus.writeEnN;
	assign wrActive = selected && !bus.writeEnN;
	// commit on the first rising strobe; a power fail mid-write drops it
	assign commitEn = wrPrev && !wrActive && busOk;

	always_ff @(posedge mclk) begin
		if (reset) begin
			wrPrev <= 1'b0;
		end else begin
			wrPrev <= wrActive;
		end
	end

	// last sampled address and data before the strobe rose are used
	always_ff @(posedge mclk) begin
		if (wrActive) begin
			wrAddr <= bus.byteAddr;
			wrData <= bus.dataIn;
		end
	end

	// ----------------------------------------------------------------
	// storage: plain bytes, control byte, clock image
	// ----------------------------------------------------------------
	logic [7:0] mem [0:8183];
	logic [7:0] ctrl;
	logic [7:0] image [1:7];
	logic [7:0] count [1:7];
	logic frozen;
	logic loadCounters;
	logic tick;
	logic tickDly;
	logic [`TKS_CNT_W-1:0] secCnt;

	assign frozen = ctrl[`TKS_READ_BIT] | ctrl[`TKS_WRITE_BIT];
	assign loadCounters = commitEn && wrAddr == `TKS_CTRL_ADDR
		&& ctrl[`TKS_WRITE_BIT] && !wrData[`TKS_WRITE_BIT];

	always_ff @(posedge mclk) begin
		if (commitEn && wrAddr < `TKS_CTRL_ADDR) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl <= `TKS_CTRL_RESET;
		end else if (powerUp) begin
			ctrl[`TKS_WRITE_BIT:`TKS_READ_BIT] <= 2'b00;
		end else if (commitEn && wrAddr == `TKS_CTRL_ADDR) begin
			ctrl <= wrData;
		end
	end

	// single-cycle refresh: a freeze written now takes effect after it
	always_ff @(posedge mclk) begin
		for (int i = 1; i <= 7; i++) begin
			if (reset) begin
				image[i] <= (i >= 4) ? `TKS_RST_DAY : `TKS_RST_SEC;
			end else if (tickDly && !frozen) begin
				image[i] <= (image[i] & ~fieldMask(i)) | count[i];
			end else if (commitEn && wrAddr == `TKS_IMG_BASE + 13'(i - 1)) begin
				image[i] <= wrData;
			end
		end
	end

	// ----------------------------------------------------------------
	// running counters, never stopped by freeze or power fail
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset || secCnt == '0) begin
			secCnt <= `TKS_CNT_W'(ONE_SEC_CYCLES - 1);
		end else begin
			secCnt <= secCnt - 1'b1;
		end
	end

	assign tick = (secCnt == '0);

	always_ff @(posedge mclk) begin
		if (reset) begin
			tickDly <= 1'b0;
		end else begin
			tickDly <= tick;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 1; i <= 7; i++) begin
				count[i] <= (i >= 4) ? `TKS_RST_DAY : `TKS_RST_SEC;
			end
		end else if (loadCounters) begin
			for (int i = 1; i <= 7; i++) begin
				count[i] <= image[i] & fieldMask(i);
			end
		end else if (tick) begin
			count[1] <= bcdInc(count[1]);
			if (count[1] == 8'h59) begin
				count[1] <= 8'h00;
				count[2] <= bcdInc(count[2]);
				if (count[2] == 8'h59) begin
					count[2] <= 8'h00;
					count[3] <= bcdInc(count[3]);
					if (count[3] == 8'h23) begin
						count[3] <= 8'h00;
						count[4] <= (count[4] == 8'h07) ? 8'h01 : bcdInc(count[4]);
						count[5] <= bcdInc(count[5]);
						if (count[5] == lastDate(count[6], count[7])) begin
							count[5] <= 8'h01;
							count[6] <= bcdInc(count[6]);
							if (count[6] == 8'h12) begin
								count[6] <= 8'h01;
								count[7] <= (count[7] == 8'h99) ? 8'h00 : bcdInc(count[7]);
							end
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read path with access delay
	// ----------------------------------------------------------------
	logic [12:0] lastAddr;
	logic readPrev;
	logic accessStart;
	logic [4:0] accessCnt;
	logic [7:0] readByte;

	assign accessStart = readMode && (!readPrev || bus.byteAddr != lastAddr);

	always_comb begin
		if (bus.byteAddr == `TKS_CTRL_ADDR) begin
			readByte = ctrl;
		end else if (isImage(bus.byteAddr)) begin
			readByte = image[3'(bus.byteAddr - `TKS_CTRL_ADDR)];
		end else begin
			readByte = mem[bus.byteAddr];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			readPrev <= 1'b0;
			lastAddr <= '0;
			accessCnt <= '0;
			dataOut <= `TKS_UNDEF_BYTE;
		end else begin
			readPrev <= readMode;
			lastAddr <= bus.byteAddr;
			if (accessStart) begin
				accessCnt <= 5'(ACCESS_CYC - 1);
				dataOut <= `TKS_UNDEF_BYTE;
			end else if (accessCnt != '0) begin
				accessCnt <= accessCnt - 1'b1;
			end else if (readMode) begin
				dataOut <= readByte;
			end
		end
	end

	// write low always wins over output enable
	assign dataOe = readMode && !bus.outEnN;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence sWrBegin;
		!wrActive ##1 wrActive;
	endsequence

	sequence sWrEnd;
		wrActive ##1 !wrActive;
	endsequence

	a_oe_gating: assert property (dataOe |-> !bus.chipSelN && !bus.outEnN && busOk)
		else $error("data driven without select and output enable");
	a_we_release: assert property (dataOe ##1 !bus.writeEnN |-> !dataOe)
		else $error("write strobe did not release data lines");
	a_simul_hiz: assert property ($fell(bus.chipSelN) && !bus.writeEnN |-> !dataOe)
		else $error("data driven on simultaneous select and write");
	a_fail_quiet: assert property (deselReq |=> !dataOe && !commitEn)
		else $error("bus active during power fail");
	a_recover_hold: assert property (pwrState == PWR_FAIL && !deselReq
		|=> !busOk [*2])
		else $error("recovery deselect skipped");
	a_write_commit: assert property (sWrEnd ##0 busOk |-> commitEn)
		else $error("write end did not commit");
	a_write_once: assert property (sWrEnd |=> !commitEn [*2])
		else $error("write committed more than once");
	a_freeze_hold: assert property (frozen && !commitEn |=> $stable(image[1])
		&& $stable(image[3]))
		else $error("frozen image changed");
	a_refresh_tick: assert property (tickDly && !frozen
		|=> (image[1] & `TKS_MASK_SEC) == $past(count[1]))
		else $error("image not refreshed from counters");
	a_xfer_load: assert property (loadCounters
		|=> count[2] == ($past(image[2]) & `TKS_MASK_MIN))
		else $error("counters not loaded from image");
	a_powerup_clear: assert property (powerUp
		|=> ctrl[`TKS_WRITE_BIT:`TKS_READ_BIT] == 2'b00)
		else $error("freeze bits not cleared at power-up");
	a_read_settle: assert property (accessStart |=> dataOut == `TKS_UNDEF_BYTE)
		else $error("data valid before access time");
endmodule
`default_nettype wire

// *** dv/tks_host_model.sv ***
// host processor model driving the parallel pins of the timekeeping memory
`default_nettype none
module tks_host_model
	import tks_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] dataOut,
	input wire logic dataOe,
	output var tks_bus_s busOut
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// pins
	// ----
	logic relData = 1'b1;
	logic [7:0] drvData = 8'h00;
	initial busOut = '{1'b1, 1'b1, 1'b1, 13'h0000, 8'h00};
	// released data lines keep changing so a stale byte never looks valid;
	// sole writer of the data pins, so driven data lags the strobe by a cycle
	always @(posedge mclk) begin
		busOut.dataIn <= relData ? ~busOut.dataIn : drvData;
	end
	task automatic setPins(input logic c, o, w, input logic [12:0] a, input logic [7:0] d,
		input logic rel);
		@(posedge mclk);
		busOut.chipSelN <= c;
		busOut.outEnN <= o;
		busOut.writeEnN <= w;
		busOut.byteAddr <= a;
		relData <= rel;
		drvData <= d;
	endtask
	// ----
	// cycles
	// ----
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		setPins(1'b0, 1'b1, 1'b0, a, d, 1'b0);
		repeat (4) @(posedge mclk);
		setPins(1'b0, 1'b1, 1'b1, a, d, 1'b1);
		setPins(1'b1, 1'b1, 1'b1, a, d, 1'b1);
		repeat (3) @(posedge mclk);
	endtask
	task automatic rd(input logic [12:0] a, output logic [7:0] early, output logic [7:0] late,
		output logic oe);
		setPins(1'b0, 1'b0, 1'b1, a, 8'h00, 1'b1);
		repeat (5) @(posedge mclk);
		early = dataOut;
		repeat (16) @(posedge mclk);
		late = dataOut;
		oe = dataOe;
		setPins(1'b1, 1'b1, 1'b1, a, 8'h00, 1'b1);
		repeat (3) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the timekeeping memory port
`include "tks_params.svh"
`default_nettype none
module tb_top
	import tks_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// setup
	// ----
	localparam int SEC = 50;
	localparam int REC = 20;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic pwrFail = 1'b0;
	logic batLow = 1'b0;
	tks_bus_s bus;
	logic [7:0] dataOut;
	logic dataOe;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int mdl[int];
	logic [15:0] lfsrState = 16'h0011;
	always #2.5 mclk = ~mclk;
	tks_timekeeping_sram_port #(.ONE_SEC_CYCLES(SEC), .RECOVERY_CYCLES(REC)) u_dut (
		.mclk(mclk), .reset(reset), .busIn(bus), .belowPowerFailThreshold(pwrFail),
		.belowBatterySwitchLevel(batLow), .dataOut(dataOut), .dataOe(dataOe));
	tks_host_model u_host (.mclk(mclk), .dataOut(dataOut), .dataOe(dataOe), .busOut(bus));
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic end_sim();
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_sim();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		logic [7:0] e, l, s1, s2;
		logic o;
		logic [12:0] a;
		logic [12:0] addrQ[$];
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		cmp8(dataOut, `TKS_UNDEF_BYTE);
		cmp1(dataOe, 1'b0);
		addrQ = '{13'h0000, 13'h1FF7};
		repeat (6) begin
			lfsrState = lfsrNext(lfsrState);
			a = lfsrState[12:0];
			addrQ.push_back((a >= `TKS_CTRL_ADDR) ? a - 13'h0008 : a);
		end
		foreach (addrQ[i]) begin
			lfsrState = lfsrNext(lfsrState);
			mdl[addrQ[i]] = lfsrState[7:0];
			u_host.wr(addrQ[i], lfsrState[7:0]);
		end
		foreach (addrQ[i]) begin
			u_host.rd(addrQ[i], e, l, o);
			cmp8(e, `TKS_UNDEF_BYTE);
			cmp8(l, 8'(mdl[addrQ[i]]));
			cmp1(o, 1'b1);
		end
		// strobe during an enabled read, then select and strobe together
		a = addrQ[0];
		u_host.setPins(1'b0, 1'b0, 1'b1, a, 8'h00, 1'b1);
		repeat (20) @(posedge mclk);
		cmp1(dataOe, 1'b1);
		u_host.setPins(1'b0, 1'b0, 1'b0, a, 8'(mdl[a]), 1'b0);
		repeat (4) @(posedge mclk);
		cmp1(dataOe, 1'b0);
		u_host.setPins(1'b1, 1'b1, 1'b1, a, 8'h00, 1'b1);
		repeat (4) @(posedge mclk);
		u_host.setPins(1'b0, 1'b0, 1'b0, a, 8'hC3, 1'b0);
		repeat (4) begin
			@(posedge mclk);
			cmp1(dataOe, 1'b0);
		end
		u_host.setPins(1'b1, 1'b1, 1'b1, a, 8'h00, 1'b1);
		mdl[a] = 8'hC3;
		repeat (3) @(posedge mclk);
		u_host.rd(a, e, l, o);
		cmp8(l, 8'(mdl[a]));
		// clock image freeze, refresh and load
		u_host.wr(`TKS_CTRL_ADDR, 8'h40);
		u_host.rd(`TKS_IMG_BASE, e, s1, o);
		repeat (3 * SEC) @(posedge mclk);
		u_host.rd(`TKS_IMG_BASE, e, s2, o);
		cmp8(s2, s1);
		u_host.rd(`TKS_CTRL_ADDR, e, l, o);
		cmp8(l, 8'h40);
		u_host.wr(`TKS_CTRL_ADDR, 8'h00);
		repeat (SEC + 10) @(posedge mclk);
		u_host.rd(`TKS_IMG_BASE, e, s2, o);
		cmp1(s2 !== s1, 1'b1);
		u_host.wr(`TKS_CTRL_ADDR, 8'h80);
		u_host.wr(`TKS_IMG_BASE, 8'h30);
		repeat (2 * SEC) @(posedge mclk);
		u_host.rd(`TKS_IMG_BASE, e, l, o);
		cmp8(l, 8'h30);
		u_host.wr(`TKS_CTRL_ADDR, 8'h00);
		u_host.rd(`TKS_IMG_BASE, e, l, o);
		cmp1(l === 8'h30 || l === 8'h31, 1'b1);
		repeat (SEC - 10) @(posedge mclk);
		u_host.rd(`TKS_IMG_BASE, e, l, o);
		cmp1(l === 8'h31 || l === 8'h32, 1'b1);
		// power loss with a freeze pending
		u_host.wr(`TKS_CTRL_ADDR, 8'h40);
		a = addrQ[1];
		pwrFail <= 1'b1;
		batLow <= 1'b1;
		repeat (4) @(posedge mclk);
		u_host.wr(a, ~8'(mdl[a]));
		u_host.rd(a, e, l, o);
		cmp1(o, 1'b0);
		pwrFail <= 1'b0;
		batLow <= 1'b0;
		u_host.setPins(1'b0, 1'b0, 1'b1, a, 8'h00, 1'b1);
		repeat (8) @(posedge mclk);
		cmp1(dataOe, 1'b0);
		u_host.setPins(1'b1, 1'b1, 1'b1, a, 8'h00, 1'b1);
		repeat (REC + 4) @(posedge mclk);
		u_host.rd(a, e, l, o);
		cmp8(l, 8'(mdl[a]));
		u_host.rd(`TKS_CTRL_ADDR, e, l, o);
		cmp8(l, `TKS_CTRL_RESET);
		end_sim();
	end
endmodule
`default_nettype wire
